/* pkg/ssr_defines.svh */
// Purpose: Offsets, bit positions and reset values of the secondary status and error registers
// Assumes: Included by the package and the design files by its bare name
// Notes:   Definitions only
//
// Behaviour
// - Bit 8 of the live status word shows the sensed level of the clamp output pin, 1 for high.
// - Bit 7 of the live status word shows the sensed level of the auxiliary pin, 1 for high.
// - Bit 6 of the live status word is 1 while the supply undervoltage monitor sees a failure.
// - Bit 5 of the live status word is the blanked overcurrent comparator, 1 above threshold.
// - Bit 4 of the live status word is the desaturation comparator, 1 above threshold.
// - Bit 1 of every word is 1 when the previous message was discarded, else 0.
// - Bit 15 of the error word is set by a power-up hard reset and stays set until cleared.
// - Bit 14 of the error word is set by an overcurrent event and stays set until cleared.
// - A clear of the overcurrent flag does nothing while the live overcurrent bit is set.
// - Bit 13 of the error word is set by a desaturation event and stays set until cleared.
// - Bit 12 of the error word is set when supply undervoltage is detected.
// - A clear of the undervoltage flag is ignored while the live undervoltage bit is set.
`ifndef SSR_DEFINES_SVH
`define SSR_DEFINES_SVH

// ----------------------------------------------------------------
// Offsets
// ----------------------------------------------------------------
`define SSR_ADDR_W        8
`define SSR_OFS_LIVE      8'h12
`define SSR_OFS_ERR       8'h13

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SSR_BIT_CLAMP     8
`define SSR_BIT_AUX       7
`define SSR_BIT_UVLIVE    6
`define SSR_BIT_OCLIVE    5
`define SSR_BIT_DSLIVE    4
`define SSR_BIT_HARD      15
`define SSR_BIT_OCERR     14
`define SSR_BIT_DSERR     13
`define SSR_BIT_UVERR     12
`define SSR_BIT_VERIFY_TIMEOUT_FLAG      9
`define SSR_BIT_ADC_OVERVOLT_FLAG     6
`define SSR_BIT_ADC_UNDERVOLT_FLAG     5
`define SSR_BIT_LINK      4
`define SSR_BIT_LMI       1
`define SSR_BIT_PAR       0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SSR_RST_WORD      16'h0000
`define SSR_RST_ERR       8'h80
`define SSR_RST_LIVE      5'h00
`define SSR_SYNC_W        5

`endif

/* pkg/ssr_pkg.sv */
// Purpose: Types of the secondary status and error registers
// Assumes: Constants come from ssr_defines.svh
// Notes:   Types only
`default_nettype none
`include "ssr_defines.svh"

package ssr_pkg;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef logic [15:0]              ssr_word_type;
    typedef logic [`SSR_ADDR_W-1:0]   ssr_addr_type;

    // Sticky error flags, bit order fixed for the whole block
    typedef struct packed {
        logic hard;
        logic oc;
        logic ds;
        logic uv;
        logic verify_timeout_flag;
        logic adc_overvolt_flag;
        logic adc_undervolt_flag;
        logic link;
    } ssr_err_type;

endpackage
`default_nettype wire

/* src/ssr_sync.sv */
// Purpose: Two-stage synchroniser for a group of asynchronous levels
// Assumes: One clock, synchronous active-high reset
// Notes:   First stage feeds only the second stage
`timescale 1ns/100ps
`default_nettype none
`include "ssr_defines.svh"

module ssr_sync (
    // Clock and reset
    input  wire logic                   clk_sys,
    input  wire logic                   rst,
    // Levels
    input  wire logic [`SSR_SYNC_W-1:0] async_in,
    output logic      [`SSR_SYNC_W-1:0] sync_out
);

    logic [`SSR_SYNC_W-1:0] meta_reg;

    // ----------------------------------------------------------------
    // Per-bit double flop
    // ----------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < `SSR_SYNC_W; i = i + 1) begin : g_bit
            always_ff @(posedge clk_sys) begin
                if (rst) begin
                    meta_reg[i] <= 1'b0;
                    sync_out[i] <= 1'b0;
                end else begin
                    meta_reg[i] <= async_in[i];
                    sync_out[i] <= meta_reg[i];
                end
            end
        end
    endgenerate

endmodule
`default_nettype wire

/* src/ssr_regs.sv */
// Purpose: Live status and sticky error registers of the gate-drive side
// Assumes: Message relay delivers reads, clears and message verdicts on clk_sys
// Notes:   Pins and comparators are asynchronous and pass the synchroniser
`timescale 1ns/100ps
`default_nettype none
`include "ssr_defines.svh"

module ssr_regs (
    // Clock and reset
    input  wire logic                  clk_sys,
    input  wire logic                  rst,
    // Pins and comparators
    input  wire logic                  clamp_output_pin,
    input  wire logic                  aux_io_pin,
    input  wire logic                  supply2_undervolt_cmp,
    input  wire logic                  overcurrent_cmp,
    input  wire logic                  desat_cmp,
    // Protection events
    input  wire logic                  hard_reset_evt,
    input  wire logic                  overcurrent_evt,
    input  wire logic                  desat_evt,
    input  wire logic                  undervolt_evt,
    input  wire logic                  verify_timeout_evt,
    input  wire logic                  adc_overvolt_evt,
    input  wire logic                  adc_undervolt_evt,
    input  wire logic                  link_loss_evt,
    // Message verdict
    input  wire logic                  msg_done,
    input  wire logic                  msg_discarded,
    // Register read
    input  wire logic                  rd_req,
    input  wire ssr_pkg::ssr_addr_type rd_addr,
    output logic                       rd_valid,
    output ssr_pkg::ssr_word_type      rd_data,
    // Error clear
    input  wire logic                  clr_req,
    input  wire ssr_pkg::ssr_word_type clr_mask
);
    import ssr_pkg::*;

    logic [`SSR_SYNC_W-1:0] live_s;
    logic                   clamp_pin_level;
    logic                   aux_pin_level;
    logic                   supply2_undervolt_live;
    logic                   overcurrent_cmp_live;
    logic                   desat_cmp_live;
    ssr_err_type            err_reg;
    ssr_err_type            err_next;
    ssr_err_type            clr_v;
    logic                   last_msg_invalid_reg;
    logic                   last_msg_invalid_next;
    logic                   rd_valid_reg;
    logic                   rd_valid_next;
    ssr_word_type           rd_data_reg;
    ssr_word_type           rd_data_next;
    ssr_word_type           word_v;

    // ----------------------------------------------------------------
    // Input synchronisation
    // ----------------------------------------------------------------
    ssr_sync u_sync (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .async_in ({clamp_output_pin, aux_io_pin, supply2_undervolt_cmp,
                    overcurrent_cmp, desat_cmp}),
        .sync_out (live_s)
    );

    assign clamp_pin_level        = live_s[4];
    assign aux_pin_level          = live_s[3];
    assign supply2_undervolt_live = live_s[2];
    assign overcurrent_cmp_live   = live_s[1];
    assign desat_cmp_live         = live_s[0];

    // ----------------------------------------------------------------
    // Sticky error flags
    // ----------------------------------------------------------------
    always_comb begin
        clr_v = ssr_err_type'(8'h00);
        if (clr_req) begin
            clr_v.hard  = clr_mask[`SSR_BIT_HARD];
            clr_v.oc    = clr_mask[`SSR_BIT_OCERR] & ~overcurrent_cmp_live;
            clr_v.ds    = clr_mask[`SSR_BIT_DSERR];
            clr_v.uv    = clr_mask[`SSR_BIT_UVERR] & ~supply2_undervolt_live;
            clr_v.verify_timeout_flag  = clr_mask[`SSR_BIT_VERIFY_TIMEOUT_FLAG];
            clr_v.adc_overvolt_flag = clr_mask[`SSR_BIT_ADC_OVERVOLT_FLAG];
            clr_v.adc_undervolt_flag = clr_mask[`SSR_BIT_ADC_UNDERVOLT_FLAG];
            clr_v.link  = clr_mask[`SSR_BIT_LINK];
        end
        // Set wins over clear; only a clear or a reset lowers a flag
        err_next       = err_reg & ~clr_v;
        err_next.hard  = err_next.hard | hard_reset_evt;
        err_next.oc    = err_next.oc | overcurrent_evt;
        err_next.ds    = err_next.ds | desat_evt;
        err_next.uv    = err_next.uv | undervolt_evt;
        err_next.verify_timeout_flag  = err_next.verify_timeout_flag | verify_timeout_evt;
        err_next.adc_overvolt_flag = err_next.adc_overvolt_flag | adc_overvolt_evt;
        err_next.adc_undervolt_flag = err_next.adc_undervolt_flag | adc_undervolt_evt;
        err_next.link  = err_next.link | link_loss_evt;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            err_reg <= ssr_err_type'(`SSR_RST_ERR);
        end else begin
            err_reg <= err_next;
        end
    end

    // ----------------------------------------------------------------
    // Message verdict
    // ----------------------------------------------------------------
    always_comb begin
        last_msg_invalid_next = last_msg_invalid_reg;
        if (msg_done) begin
            last_msg_invalid_next = msg_discarded;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            last_msg_invalid_reg <= 1'b0;
        end else begin
            last_msg_invalid_reg <= last_msg_invalid_next;
        end
    end

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    always_comb begin
        word_v        = `SSR_RST_WORD;
        rd_valid_next = rd_req;
        rd_data_next  = rd_data_reg;
        case (rd_addr)
            `SSR_OFS_LIVE: begin
                word_v[`SSR_BIT_CLAMP]  = clamp_pin_level;
                word_v[`SSR_BIT_AUX]    = aux_pin_level;
                word_v[`SSR_BIT_UVLIVE] = supply2_undervolt_live;
                word_v[`SSR_BIT_OCLIVE] = overcurrent_cmp_live;
                word_v[`SSR_BIT_DSLIVE] = desat_cmp_live;
            end
            `SSR_OFS_ERR: begin
                word_v[`SSR_BIT_HARD]  = err_reg.hard;
                word_v[`SSR_BIT_OCERR] = err_reg.oc;
                word_v[`SSR_BIT_DSERR] = err_reg.ds;
                word_v[`SSR_BIT_UVERR] = err_reg.uv;
                word_v[`SSR_BIT_VERIFY_TIMEOUT_FLAG]  = err_reg.verify_timeout_flag;
                word_v[`SSR_BIT_ADC_OVERVOLT_FLAG] = err_reg.adc_overvolt_flag;
                word_v[`SSR_BIT_ADC_UNDERVOLT_FLAG] = err_reg.adc_undervolt_flag;
                word_v[`SSR_BIT_LINK]  = err_reg.link;
            end
            default: begin
                word_v = `SSR_RST_WORD;
            end
        endcase
        word_v[`SSR_BIT_LMI] = last_msg_invalid_reg;
        word_v[`SSR_BIT_PAR] = ~(^word_v[15:1]);
        if (rd_req) begin
            rd_data_next = word_v;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rd_valid_reg <= 1'b0;
            rd_data_reg  <= `SSR_RST_WORD;
        end else begin
            rd_valid_reg <= rd_valid_next;
            rd_data_reg  <= rd_data_next;
        end
    end

    assign rd_valid = rd_valid_reg;
    assign rd_data  = rd_data_reg;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    sequence s_live_read;
        rd_req && (rd_addr == `SSR_OFS_LIVE);
    endsequence

    sequence s_err_read;
        rd_req && (rd_addr == `SSR_OFS_ERR);
    endsequence

    a_clamp_level_bit: assert property (@(posedge clk_sys) disable iff (rst)
        s_live_read |=> rd_data[8] == $past(clamp_pin_level))
        else $error("clamp level bit wrong");

    a_aux_level_bit: assert property (@(posedge clk_sys) disable iff (rst)
        s_live_read |=> rd_valid && rd_data[7] == $past(aux_pin_level))
        else $error("aux level bit wrong");

    a_uv_live_bit: assert property (@(posedge clk_sys) disable iff (rst)
        s_live_read |=> rd_data[6] == $past(supply2_undervolt_live))
        else $error("undervoltage live bit wrong");

    a_oc_live_bit: assert property (@(posedge clk_sys) disable iff (rst)
        s_live_read |=> rd_data[5] == $past(overcurrent_cmp_live))
        else $error("overcurrent live bit wrong");

    a_ds_live_bit: assert property (@(posedge clk_sys) disable iff (rst)
        s_live_read |=> rd_data[4] == $past(desat_cmp_live))
        else $error("desaturation live bit wrong");

    a_lmi_follows_msg: assert property (@(posedge clk_sys) disable iff (rst)
        msg_done ##1 rd_req |=> rd_data[1] == $past(msg_discarded, 2))
        else $error("message invalid bit wrong");

    a_hard_after_reset: assert property (@(posedge clk_sys)
        $fell(rst) |-> err_reg.hard)
        else $error("hard reset flag not set after reset");

    a_oc_err_set: assert property (@(posedge clk_sys) disable iff (rst)
        overcurrent_evt ##1 s_err_read |=> rd_data[14])
        else $error("overcurrent flag not set");

    a_oc_clear_blocked: assert property (@(posedge clk_sys) disable iff (rst)
        err_reg.oc && overcurrent_cmp_live |=> err_reg.oc)
        else $error("overcurrent flag cleared while active");

    a_ds_err_set: assert property (@(posedge clk_sys) disable iff (rst)
        desat_evt |=> err_reg.ds)
        else $error("desaturation flag not set");

    a_uv_err_set: assert property (@(posedge clk_sys) disable iff (rst)
        undervolt_evt |=> err_reg.uv)
        else $error("undervoltage flag not set");

    a_uv_clear_blocked: assert property (@(posedge clk_sys) disable iff (rst)
        err_reg.uv && supply2_undervolt_live |=> err_reg.uv)
        else $error("undervoltage flag cleared while active");

    a_word_parity: assert property (@(posedge clk_sys) disable iff (rst)
        rd_valid |-> (^rd_data) == 1'b1 && rd_data[3:2] == 2'b00)
        else $error("returned word not odd parity");

    a_sticky_hold: assert property (@(posedge clk_sys) disable iff (rst)
        err_reg.ds && !clr_req |=> err_reg.ds)
        else $error("sticky flag dropped without clear");

endmodule
`default_nettype wire

/* test/ssr_host_model.sv */
// Purpose: Host side relay model issuing reads, clears and message verdicts
// Assumes: Requests change 1 ns after a rising edge of clk_sys
// Notes:   Released request lines show the inverse of their last value
`timescale 1ns/100ps
`default_nettype none

module ssr_host_model (
    // Clock
    input  wire logic                  clk_sys,
    // Register read
    output logic                       rd_req,
    output ssr_pkg::ssr_addr_type      rd_addr,
    input  wire logic                  rd_valid,
    input  wire ssr_pkg::ssr_word_type rd_data,
    // Error clear
    output logic                       clr_req,
    output ssr_pkg::ssr_word_type      clr_mask,
    // Message verdict
    output logic                       msg_done,
    output logic                       msg_discarded
);
    import ssr_pkg::*;

    initial begin
        rd_req        = 1'b0;
        rd_addr       = 8'h00;
        clr_req       = 1'b0;
        clr_mask      = 16'h0000;
        msg_done      = 1'b0;
        msg_discarded = 1'b0;
    end

    // ----------------------------------------------------------------
    // Requests
    // ----------------------------------------------------------------
    task automatic read_word(input ssr_addr_type addr, output ssr_word_type data);
        int n;
        n = 0;
        @(posedge clk_sys);
        #1;
        rd_req  = 1'b1;
        rd_addr = addr;
        @(posedge clk_sys);
        #1;
        rd_req  = 1'b0;
        rd_addr = ~addr;
        while (rd_valid !== 1'b1 && n < 4) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        data = (rd_valid === 1'b1) ? rd_data : 16'hxxxx;
    endtask

    // Only an explicit clear or a reset lowers a sticky flag
    task automatic clear_flags(input ssr_word_type mask);
        @(posedge clk_sys);
        #1;
        clr_req  = 1'b1;
        clr_mask = mask;
        @(posedge clk_sys);
        #1;
        clr_req  = 1'b0;
        clr_mask = ~mask;
    endtask

    task automatic verdict(input logic discarded);
        @(posedge clk_sys);
        #1;
        msg_done      = 1'b1;
        msg_discarded = discarded;
        @(posedge clk_sys);
        #1;
        msg_done      = 1'b0;
        msg_discarded = ~discarded;
    endtask

endmodule

`default_nettype wire

/* test/testbench.sv */
// Purpose: Self-checking bench of the secondary status and error registers
// Assumes: Inputs change 1 ns after a rising edge; first reset held 4 cycles, second reset 2
// Notes:   Expected words are built with odd parity in bit 0
`timescale 1ns/100ps
`default_nettype none
`include "ssr_defines.svh"

module testbench;
    import ssr_pkg::*;

    logic         clk_sys   = 1'b0;
    logic         rst       = 1'b1;
    logic [4:0]   pins      = 5'h00;
    logic [7:0]   evt       = 8'h00;
    logic         rd_req;
    logic         rd_valid;
    logic         clr_req;
    logic         msg_done;
    logic         msg_discarded;
    ssr_addr_type rd_addr;
    ssr_word_type rd_data;
    ssr_word_type clr_mask;
    int           err_count = 0;
    int           cmp_count = 0;
    int           cycles    = 0;
    int           pos [8]   = '{`SSR_BIT_HARD, `SSR_BIT_OCERR, `SSR_BIT_DSERR, `SSR_BIT_UVERR,
                                `SSR_BIT_VERIFY_TIMEOUT_FLAG, `SSR_BIT_ADC_OVERVOLT_FLAG, `SSR_BIT_ADC_UNDERVOLT_FLAG, `SSR_BIT_LINK};
    int           bpin [2]  = '{1, 2};
    int           bev [2]   = '{1, 3};

    always #2.5 clk_sys = ~clk_sys;

    // ----------------------------------------------------------------
    // Design and host
    // ----------------------------------------------------------------
    ssr_regs dut_u (
        .clk_sys(clk_sys), .rst(rst),
        .clamp_output_pin(pins[4]), .aux_io_pin(pins[3]), .supply2_undervolt_cmp(pins[2]),
        .overcurrent_cmp(pins[1]), .desat_cmp(pins[0]),
        .hard_reset_evt(evt[0]), .overcurrent_evt(evt[1]), .desat_evt(evt[2]),
        .undervolt_evt(evt[3]), .verify_timeout_evt(evt[4]), .adc_overvolt_evt(evt[5]),
        .adc_undervolt_evt(evt[6]), .link_loss_evt(evt[7]),
        .msg_done(msg_done), .msg_discarded(msg_discarded),
        .rd_req(rd_req), .rd_addr(rd_addr), .rd_valid(rd_valid), .rd_data(rd_data),
        .clr_req(clr_req), .clr_mask(clr_mask)
    );

    ssr_host_model host_u (
        .clk_sys(clk_sys), .rd_req(rd_req), .rd_addr(rd_addr), .rd_valid(rd_valid),
        .rd_data(rd_data), .clr_req(clr_req), .clr_mask(clr_mask),
        .msg_done(msg_done), .msg_discarded(msg_discarded)
    );

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic ssr_word_type mk(input ssr_word_type v);
        mk = {v[15:1], ~^v[15:1]};
    endfunction

    task automatic check(input string name, input ssr_word_type seen, input ssr_word_type exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic rd_chk(input string name, input ssr_addr_type a, input ssr_word_type exp);
        ssr_word_type d;
        host_u.read_word(a, d);
        check(name, d, exp);
    endtask

    task automatic pulse(input int i);
        @(posedge clk_sys);
        #1;
        evt[i] = 1'b1;
        @(posedge clk_sys);
        #1;
        evt = 8'h00;
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            results();
        end
    end

    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial begin
        repeat (4) @(posedge clk_sys);
        #1;
        rst = 1'b0;
        rd_chk("error after reset", `SSR_OFS_ERR, mk(16'h8000));
        rd_chk("live after reset", `SSR_OFS_LIVE, mk(16'h0000));
        rd_chk("unmapped", 8'h20, mk(16'h0000));
        host_u.clear_flags(16'h8000);
        rd_chk("hard flag cleared", `SSR_OFS_ERR, mk(16'h0000));
        for (int i = 0; i < 5; i++) begin
            pins = 5'h01 << i;
            repeat (3) @(posedge clk_sys);
            #1;
            rd_chk("live pin", `SSR_OFS_LIVE, mk({7'h00, pins, 4'h0}));
        end
        pins = 5'h00;
        repeat (3) @(posedge clk_sys);
        for (int i = 0; i < 8; i++) begin
            pulse(i);
            rd_chk("flag set", `SSR_OFS_ERR, mk(16'h0001 << pos[i]));
            repeat (8) @(posedge clk_sys);
            rd_chk("flag held", `SSR_OFS_ERR, mk(16'h0001 << pos[i]));
            host_u.clear_flags(16'h0001 << pos[i]);
            rd_chk("flag cleared", `SSR_OFS_ERR, mk(16'h0000));
        end
        for (int j = 0; j < 2; j++) begin
            pins[bpin[j]] = 1'b1;
            pulse(bev[j]);
            repeat (3) @(posedge clk_sys);
            host_u.clear_flags(16'h0001 << pos[bev[j]]);
            rd_chk("blocked clear", `SSR_OFS_ERR, mk(16'h0001 << pos[bev[j]]));
            pins = 5'h00;
            repeat (3) @(posedge clk_sys);
            host_u.clear_flags(16'h0001 << pos[bev[j]]);
            rd_chk("allowed clear", `SSR_OFS_ERR, mk(16'h0000));
        end
        host_u.verdict(1'b1);
        rd_chk("discard live", `SSR_OFS_LIVE, mk(16'h0002));
        rd_chk("discard error", `SSR_OFS_ERR, mk(16'h0002));
        rd_chk("discard unmapped", 8'h7f, mk(16'h0002));
        host_u.verdict(1'b0);
        rd_chk("accepted live", `SSR_OFS_LIVE, mk(16'h0000));
        fork
            pulse(2);
            host_u.clear_flags(16'h2000);
        join
        rd_chk("set beats clear", `SSR_OFS_ERR, mk(16'h2000));
        host_u.verdict(1'b1);
        @(posedge clk_sys);
        #1;
        rst = 1'b1;
        repeat (2) @(posedge clk_sys);
        #1;
        rst = 1'b0;
        rd_chk("error after second reset", `SSR_OFS_ERR, mk(16'h8000));
        results();
    end

endmodule

`default_nettype wire
